// file: asu_status_unit.sv
// adapter unit status, sense, attention latching and display module status bytes
//
// Behaviour
// R1 - operator busy bit tracks operator unit activity
// R2 - interrupt bit set on interrupt, cleared by read
// R3 - fetch clears, completion sets, rise raises line A
// R4 - console entry rise raises line B, interrupt
// R5 - error summary bits are OR of bytes
// R6 - order parity error sets error one bit 2
// R7 - constant parity error sets error one bit 3
// R8 - no read queue in time sets bit 4
// R9 - bad length or busy command sets bit 5
// R10 - silent console sets bit 6, request clears
// R11 - queue overflow bit cleared only by load
// R12 - bad or parity-failing command sets error two
// R13 - unit status presented on every ending
// R14 - foreign address while operating gives busy, modifier
// R15 - control unit end added after busy modifier
// R16 - unit check alone on bus parity or reject
// R17 - attention names source, modifier or exception
// R18 - sense bits 0 and 2 for reject, parity
// R19 - 112 us demand gap sets intervention required
// R20 - data check from read or transmit buffer parity
// R21 - module fault during transfer sets module error
// R22 - reply missing 1.9 us after strobe, timeout
// R23 - latch five attentions, present when free or with the ending status
// R24 - reading an error or sense byte clears its bits, except the queue overflow bit
// R25 - attentions presented lowest module number first
`include "asu_defines.svh"
module asu_status_unit #(
  parameter int unsigned NORESP_CYCLES = `ASU_NORESP_CYC,
  parameter int unsigned IREQ_CYCLES = `ASU_IREQ_CYC
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic OPER_BUSY_IN,
  input wire logic POLLING_IN,
  input wire logic ORDER_IN,
  input wire logic ORDER_STATUS_IN,
  input wire logic DISC_IN,
  input wire logic ORDER_BAD_IN,
  input wire logic ORDER_PERR_IN,
  input wire logic FIXLEN_ERR_IN,
  input wire logic FETCH_REQ_IN,
  input wire logic FETCH_DONE_IN,
  input wire logic CONST_PERR_IN,
  input wire logic NO_CONSOLE_IN,
  input wire logic POLL_STORED_IN,
  input wire logic QADDR_READ_IN,
  input wire logic READ_QUEUE_IN,
  input wire logic QADDR_MAX_IN,
  input wire logic LOAD_QADDR_IN,
  input wire logic OVERTEMP_IN,
  input wire logic PSU_FAIL_IN,
  input wire logic [6:0] ERR2_IN,
  output logic INT_A_OUT,
  output logic INT_B_OUT,
  input wire logic STAT_RD_IN,
  input wire asu_pkg::asu_rsel_t STAT_SEL_IN,
  output asu_pkg::asu_byte_t STAT_DATA_OUT,
  output logic STAT_VALID_OUT,
  input wire asu_pkg::asu_mods_t MOD_INT_A_IN,
  input wire asu_pkg::asu_mods_t MOD_INT_B_IN,
  input wire logic SEL_IN,
  input wire logic [2:0] SEL_ADDR_IN,
  input wire logic SEL_INVALID_IN,
  input wire logic SEL_PERR_IN,
  input wire logic END_IN,
  input wire logic END_UNUSUAL_IN,
  output asu_pkg::asu_byte_t USTAT_OUT,
  output logic [2:0] USTAT_SRC_OUT,
  output logic USTAT_VALID_OUT,
  input wire logic XFER_ACTIVE_IN,
  input wire logic XFER_READ_IN,
  input wire logic XFER_START_IN,
  input wire logic DEMAND_IN,
  input wire logic MOD_FAULT_IN,
  input wire logic RD_PERR_IN,
  input wire logic TXA_PERR_IN,
  input wire logic STROBE_IN,
  input wire logic REPLY_IN
);
  import asu_pkg::*;

  localparam int NRW = $clog2(NORESP_CYCLES + 1);
  localparam int IRW = $clog2(IREQ_CYCLES + 1);
  localparam int RPW = $clog2(`ASU_REPLY_CYC + 1);

  function automatic logic [2:0] first_set(input asu_mods_t v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 4; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  asu_mods_t ia_s1, ia_s2, ia_s3, ib_s1, ib_s2, ib_s3;
  logic [2:0] pin_s1, pin_s2;
  logic dem_s3;
  logic dem_s, fault_s, reply_s, dem_rise;

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ia_s1 <= 5'h00;
      ia_s2 <= 5'h00;
      ia_s3 <= 5'h00;
      ib_s1 <= 5'h00;
      ib_s2 <= 5'h00;
      ib_s3 <= 5'h00;
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      dem_s3 <= 1'b0;
    end else begin
      ia_s1 <= MOD_INT_A_IN;
      ia_s2 <= ia_s1;
      ia_s3 <= ia_s2;
      ib_s1 <= MOD_INT_B_IN;
      ib_s2 <= ib_s1;
      ib_s3 <= ib_s2;
      pin_s1 <= {DEMAND_IN, MOD_FAULT_IN, REPLY_IN};
      pin_s2 <= pin_s1;
      dem_s3 <= pin_s2[2];
    end
  end

  assign dem_s = pin_s2[2];
  assign fault_s = pin_s2[1];
  assign reply_s = pin_s2[0];
  assign dem_rise = dem_s & ~dem_s3;

  ////////////////////////////////////////////////////////////////////////////
  // display module status bytes
  logic gs_busy, gs_int, gs_fetched, gs_centry;
  asu_byte_t err1, err2, gs_byte, set1, clr1, set2;
  logic valid_order, fetch_rise, centry_rise, rd_gs, rd_e1, rd_e2, rd_sn;
  logic nr_run, nr_hit;
  logic [NRW-1:0] nr_cnt;

  assign rd_gs = STAT_RD_IN && STAT_SEL_IN == ASU_RD_GEN;
  assign rd_e1 = STAT_RD_IN && STAT_SEL_IN == ASU_RD_ERR1;
  assign rd_e2 = STAT_RD_IN && STAT_SEL_IN == ASU_RD_ERR2;
  assign rd_sn = STAT_RD_IN && STAT_SEL_IN == ASU_RD_SENSE;
  assign valid_order = ORDER_IN & ~ORDER_STATUS_IN & ~DISC_IN & ~ORDER_BAD_IN;
  assign fetch_rise = FETCH_DONE_IN & ~gs_fetched; // R3
  assign centry_rise = POLL_STORED_IN & ~gs_centry; // R4
  assign nr_hit = nr_run && !READ_QUEUE_IN && nr_cnt == NRW'(NORESP_CYCLES - 1);

  always_comb begin
    gs_byte = `ASU_BYTE_RST;
    gs_byte[`ASU_GS_BUSY] = gs_busy;
    gs_byte[`ASU_GS_OPBUSY] = OPER_BUSY_IN; // R1
    gs_byte[`ASU_GS_INT] = gs_int;
    gs_byte[`ASU_GS_FETCHED] = gs_fetched;
    gs_byte[`ASU_GS_CENTRY] = gs_centry;
    gs_byte[`ASU_GS_POLL] = POLLING_IN;
    gs_byte[`ASU_GS_ERR2] = |err2; // R5
    gs_byte[`ASU_GS_ERR1] = |err1; // R5
    set1 = `ASU_BYTE_RST;
    set1[`ASU_E1_OVT] = OVERTEMP_IN;
    set1[`ASU_E1_PSU] = PSU_FAIL_IN;
    set1[`ASU_E1_BOPE] = ORDER_PERR_IN; // R6
    set1[`ASU_E1_CPE] = CONST_PERR_IN; // R7
    set1[`ASU_E1_NORESP] = nr_hit; // R8
    set1[`ASU_E1_PROC] = FIXLEN_ERR_IN | (valid_order & gs_busy); // R9
    set1[`ASU_E1_CNS] = NO_CONSOLE_IN; // R10
    set1[`ASU_E1_QOVF] = QADDR_MAX_IN; // R11
    clr1 = rd_e1 ? 8'hFF : 8'h00; // R24
    clr1[`ASU_E1_CNS] = rd_e1 | FETCH_REQ_IN; // R10
    clr1[`ASU_E1_QOVF] = LOAD_QADDR_IN; // R11
    set2 = {ORDER_BAD_IN, ERR2_IN}; // R12
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      err1 <= `ASU_BYTE_RST;
      err2 <= `ASU_BYTE_RST;
    end else begin
      err1 <= (err1 & ~clr1) | set1;
      err2 <= (rd_e2 ? 8'h00 : err2) | set2; // R24
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      gs_busy <= 1'b0;
      gs_int <= 1'b0;
      gs_fetched <= 1'b0;
      gs_centry <= 1'b0;
      INT_A_OUT <= 1'b0;
      INT_B_OUT <= 1'b0;
    end else begin
      gs_busy <= (gs_busy & ~DISC_IN) | valid_order;
      gs_int <= (gs_int & ~rd_gs) | fetch_rise | centry_rise; // R2
      gs_fetched <= (gs_fetched & ~FETCH_REQ_IN) | FETCH_DONE_IN; // R3
      gs_centry <= (gs_centry & ~QADDR_READ_IN) | POLL_STORED_IN; // R4
      INT_A_OUT <= (INT_A_OUT & ~rd_gs) | fetch_rise; // R3
      INT_B_OUT <= (INT_B_OUT & ~rd_gs) | centry_rise; // R4
    end
  end

  // read-queue watchdog after line B
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      nr_run <= 1'b0;
      nr_cnt <= '0;
    end else if (centry_rise) begin
      nr_run <= 1'b1;
      nr_cnt <= '0;
    end else if (READ_QUEUE_IN || nr_hit) begin
      nr_run <= 1'b0; // R8
    end else if (nr_run) begin
      nr_cnt <= nr_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attention latches, five modules
  asu_mods_t att_a, att_b, att_all, att_clr;
  logic att_any, ending, free_att;
  logic [2:0] att_idx;

  assign att_all = att_a | att_b;
  assign att_any = |att_all;
  assign att_idx = first_set(att_all); // R25

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      att_a <= 5'h00;
      att_b <= 5'h00;
    end else begin
      att_a <= (att_a & ~att_clr) | (ia_s2 & ~ia_s3); // R23
      att_b <= (att_b & ~att_clr) | (ib_s2 & ~ib_s3); // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unit status towards the channel
  asu_op_t op_state;
  logic [2:0] op_addr;
  logic cue_pend, sel_reject, foreign;
  asu_byte_t att_bits;

  assign sel_reject = SEL_IN && op_state == ASU_OP_IDLE && (SEL_INVALID_IN || SEL_PERR_IN);
  assign foreign = SEL_IN && op_state == ASU_OP_RUN && SEL_ADDR_IN != op_addr;
  assign ending = !SEL_IN && END_IN && op_state == ASU_OP_RUN;
  assign free_att = !SEL_IN && !END_IN && op_state == ASU_OP_IDLE && att_any; // R23

  always_comb begin
    att_bits = `ASU_BYTE_RST;
    att_clr = 5'h00;
    if (att_any && (ending || free_att)) begin
      att_bits[`ASU_US_ATT] = 1'b1;
      att_bits[`ASU_US_SM] = att_a[att_idx]; // R17
      att_bits[`ASU_US_UE] = att_b[att_idx]; // R17
      att_clr[att_idx] = 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      op_state <= ASU_OP_IDLE;
      op_addr <= 3'h0;
      cue_pend <= 1'b0;
      USTAT_OUT <= `ASU_BYTE_RST;
      USTAT_SRC_OUT <= 3'h0;
      USTAT_VALID_OUT <= 1'b0;
    end else begin
      USTAT_VALID_OUT <= 1'b0;
      unique case (op_state)
        ASU_OP_IDLE: begin
          if (sel_reject) begin
            USTAT_OUT <= 8'h01 << `ASU_US_UC; // R16
            USTAT_SRC_OUT <= SEL_ADDR_IN;
            USTAT_VALID_OUT <= 1'b1;
          end else if (SEL_IN) begin
            op_state <= ASU_OP_RUN;
            op_addr <= SEL_ADDR_IN;
          end else if (free_att) begin
            USTAT_OUT <= att_bits | ({7'h00, cue_pend} << `ASU_US_CUE); // R15
            USTAT_SRC_OUT <= att_idx; // R17
            USTAT_VALID_OUT <= 1'b1;
            cue_pend <= 1'b0;
          end
        end
        ASU_OP_RUN: begin
          if (SEL_IN) begin
            USTAT_OUT <= (8'h01 << `ASU_US_BUSY) | ({7'h00, foreign} << `ASU_US_SM); // R14
            USTAT_SRC_OUT <= SEL_ADDR_IN;
            USTAT_VALID_OUT <= 1'b1;
            cue_pend <= cue_pend | foreign; // R15
          end else if (END_IN) begin
            USTAT_OUT <= att_bits | (8'h01 << `ASU_US_CE) | (8'h01 << `ASU_US_DE)
              | ({7'h00, END_UNUSUAL_IN} << `ASU_US_UC)
              | ({7'h00, cue_pend} << `ASU_US_CUE); // R13 R15
            USTAT_SRC_OUT <= att_any ? att_idx : op_addr;
            USTAT_VALID_OUT <= 1'b1; // R13
            cue_pend <= 1'b0;
            op_state <= ASU_OP_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sense byte and transfer watchdogs
  asu_byte_t sense, sn_set;
  logic [IRW-1:0] iv_cnt;
  logic [RPW-1:0] rp_cnt;
  logic rp_run, iv_hit, rp_hit;

  assign iv_hit = XFER_ACTIVE_IN && !XFER_START_IN && !dem_rise
    && iv_cnt == IRW'(IREQ_CYCLES - 1);
  assign rp_hit = rp_run && !reply_s && rp_cnt == RPW'(`ASU_REPLY_CYC - 1);

  always_comb begin
    sn_set = `ASU_BYTE_RST;
    sn_set[`ASU_SN_CR] = SEL_IN && op_state == ASU_OP_IDLE && SEL_INVALID_IN; // R18
    sn_set[`ASU_SN_BOC] = SEL_IN && op_state == ASU_OP_IDLE && SEL_PERR_IN; // R18
    sn_set[`ASU_SN_IR] = iv_hit; // R19
    sn_set[`ASU_SN_DC] = XFER_ACTIVE_IN
      && (XFER_READ_IN ? RD_PERR_IN : TXA_PERR_IN); // R20
    sn_set[`ASU_SN_MERR] = XFER_ACTIVE_IN && fault_s; // R21
    sn_set[`ASU_SN_TO] = rp_hit; // R22
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sense <= `ASU_BYTE_RST;
    end else begin
      sense <= (rd_sn ? 8'h00 : sense) | sn_set;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      iv_cnt <= '0;
    end else if (!XFER_ACTIVE_IN || XFER_START_IN || dem_rise) begin
      iv_cnt <= '0; // R19
    end else if (iv_cnt != IRW'(IREQ_CYCLES)) begin
      iv_cnt <= iv_cnt + 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rp_run <= 1'b0;
      rp_cnt <= '0;
    end else if (STROBE_IN) begin
      rp_run <= 1'b1;
      rp_cnt <= '0;
    end else if (reply_s || rp_hit) begin
      rp_run <= 1'b0; // R22
    end else if (rp_run) begin
      rp_cnt <= rp_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status read port: snapshot taken before the clear
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      STAT_DATA_OUT <= `ASU_BYTE_RST;
      STAT_VALID_OUT <= 1'b0;
    end else begin
      STAT_VALID_OUT <= STAT_RD_IN;
      if (STAT_RD_IN) begin
        unique case (STAT_SEL_IN)
          ASU_RD_GEN: STAT_DATA_OUT <= gs_byte;
          ASU_RD_ERR1: STAT_DATA_OUT <= err1;
          ASU_RD_ERR2: STAT_DATA_OUT <= err2;
          ASU_RD_SENSE: STAT_DATA_OUT <= sense;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_line_a;
    @(posedge MCLK_IN) disable iff (RST_IN) fetch_rise |=> INT_A_OUT && gs_int && gs_fetched;
  endproperty
  a_line_a: assert property (p_line_a) else $error("line A or interrupt bit missing"); // R3

  property p_line_b;
    @(posedge MCLK_IN) disable iff (RST_IN) centry_rise |=> INT_B_OUT && gs_int && nr_run;
  endproperty
  a_line_b: assert property (p_line_b) else $error("line B or interrupt bit missing"); // R4

  property p_gs_read;
    @(posedge MCLK_IN) disable iff (RST_IN)
      rd_gs && !fetch_rise && !centry_rise |=> !gs_int && !INT_A_OUT && STAT_VALID_OUT
      && STAT_DATA_OUT == $past(gs_byte);
  endproperty
  a_gs_read: assert property (p_gs_read) else $error("general status read wrong"); // R2

  property p_noresp;
    @(posedge MCLK_IN) disable iff (RST_IN) nr_hit |=> err1[`ASU_E1_NORESP] && !nr_run;
  endproperty
  a_noresp: assert property (p_noresp) else $error("no-response bit not set"); // R8

  property p_qovf;
    @(posedge MCLK_IN) disable iff (RST_IN)
      err1[`ASU_E1_QOVF] && !LOAD_QADDR_IN |=> err1[`ASU_E1_QOVF];
  endproperty
  a_qovf: assert property (p_qovf) else $error("queue overflow lost"); // R11

  property p_busy_sm;
    @(posedge MCLK_IN) disable iff (RST_IN)
      foreign |=> USTAT_VALID_OUT && USTAT_OUT == 8'h50 && cue_pend;
  endproperty
  a_busy_sm: assert property (p_busy_sm) else $error("busy with modifier not shown"); // R14

  property p_cue;
    @(posedge MCLK_IN) disable iff (RST_IN)
      cue_pend && ending |=> USTAT_OUT[`ASU_US_CUE] && USTAT_OUT[`ASU_US_CE] && !cue_pend;
  endproperty
  a_cue: assert property (p_cue) else $error("control unit end not added"); // R15

  property p_uc_alone;
    @(posedge MCLK_IN) disable iff (RST_IN)
      sel_reject |=> USTAT_VALID_OUT && USTAT_OUT == 8'h02 && op_state == ASU_OP_IDLE;
  endproperty
  a_uc_alone: assert property (p_uc_alone) else $error("unit check not alone"); // R16

  property p_free_att;
    @(posedge MCLK_IN) disable iff (RST_IN)
      free_att |=> USTAT_VALID_OUT && USTAT_OUT[`ASU_US_ATT] && USTAT_SRC_OUT == $past(att_idx);
  endproperty
  a_free_att: assert property (p_free_att) else $error("attention not presented"); // R23

  property p_timeout;
    @(posedge MCLK_IN) disable iff (RST_IN) rp_hit |=> sense[`ASU_SN_TO] && !rp_run;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout sense not set"); // R22

  property p_ireq;
    @(posedge MCLK_IN) disable iff (RST_IN) iv_hit |=> sense[`ASU_SN_IR];
  endproperty
  a_ireq: assert property (p_ireq) else $error("intervention sense not set"); // R19

  c_busy_sm: cover property (@(posedge MCLK_IN) disable iff (RST_IN) foreign ##[1:50] ending);
  c_att: cover property (@(posedge MCLK_IN) disable iff (RST_IN) free_att ##1 free_att);
  c_noresp: cover property (@(posedge MCLK_IN) disable iff (RST_IN) nr_hit);
  c_timeout: cover property (@(posedge MCLK_IN) disable iff (RST_IN) rp_hit);
endmodule // asu_status_unit

// file: asu_defines.svh
// bit positions, reset values and timing counts for the adapter status unit
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH
// clock rate and times as printed
`define ASU_CLK_MHZ 100
`define ASU_NORESP_MS 36
`define ASU_NORESP_CYC (`ASU_NORESP_MS * 1000 * `ASU_CLK_MHZ)
`define ASU_IREQ_US 112
`define ASU_IREQ_CYC (`ASU_IREQ_US * `ASU_CLK_MHZ)
`define ASU_REPLY_NS 1900
`define ASU_REPLY_CYC ((`ASU_REPLY_NS * `ASU_CLK_MHZ) / 1000)
// byte bit n sits at vector index 7-n (bit 0 is the msb)
`define ASU_GS_BUSY 7
`define ASU_GS_OPBUSY 6
`define ASU_GS_INT 5
`define ASU_GS_FETCHED 4
`define ASU_GS_CENTRY 3
`define ASU_GS_POLL 2
`define ASU_GS_ERR2 1
`define ASU_GS_ERR1 0
`define ASU_E1_OVT 7
`define ASU_E1_PSU 6
`define ASU_E1_BOPE 5
`define ASU_E1_CPE 4
`define ASU_E1_NORESP 3
`define ASU_E1_PROC 2
`define ASU_E1_CNS 1
`define ASU_E1_QOVF 0
`define ASU_E2_INVCMD 7
`define ASU_US_ATT 7
`define ASU_US_SM 6
`define ASU_US_CUE 5
`define ASU_US_BUSY 4
`define ASU_US_CE 3
`define ASU_US_DE 2
`define ASU_US_UC 1
`define ASU_US_UE 0
`define ASU_SN_CR 7
`define ASU_SN_IR 6
`define ASU_SN_BOC 5
`define ASU_SN_DC 3
`define ASU_SN_MERR 2
`define ASU_SN_TO 0
`define ASU_BYTE_RST 8'h00
`endif

// file: asu_pkg.sv
// types shared by the adapter status unit
package asu_pkg;
  typedef logic [7:0] asu_byte_t;
  typedef logic [4:0] asu_mods_t;
  typedef enum logic [1:0] {
    ASU_RD_GEN = 2'b00,
    ASU_RD_ERR1 = 2'b01,
    ASU_RD_ERR2 = 2'b10,
    ASU_RD_SENSE = 2'b11
  } asu_rsel_t;
  typedef enum logic [0:0] {
    ASU_OP_IDLE = 1'b0,
    ASU_OP_RUN = 1'b1
  } asu_op_t;
endpackage : asu_pkg

// file: asu_partner.sv
// behavioural display module side: interrupt lines, demand, fault and reply
module asu_partner (
  input wire logic clk_in,
  input wire logic strobe_in,
  input wire logic reply_en_in,
  input wire logic fault_in,
  input wire asu_pkg::asu_mods_t int_a_in,
  input wire asu_pkg::asu_mods_t int_b_in,
  input wire logic [7:0] gap_in,
  output asu_pkg::asu_mods_t int_a_out,
  output asu_pkg::asu_mods_t int_b_out,
  output logic demand_out,
  output logic fault_out,
  output logic reply_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import asu_pkg::*;
  int rcnt = 0;
  int dcnt = 0;
  logic pend = 1'h0;
  // interrupt levels follow the bench, which holds each one at least 3 cycles
  assign int_a_out = int_a_in;
  assign int_b_out = int_b_in;
  assign fault_out = fault_in;
  ////////////////////////////////////////
  // reply comes 17 cycles after a strobe, well inside the limit, then drops
  always @(posedge clk_in) begin
    if (strobe_in && reply_en_in) begin
      pend <= 1'h1;
      rcnt <= 0;
    end else if (pend) begin
      rcnt <= rcnt + 1;
      if (rcnt == 20) begin
        pend <= 1'h0;
      end
    end
  end
  assign reply_out = pend && (rcnt >= 17);
  // demand repeats every gap plus one cycles while a gap is given
  always @(posedge clk_in) begin
    dcnt <= (gap_in == 8'h00 || dcnt >= int'(gap_in)) ? 0 : dcnt + 1;
  end
  assign demand_out = (gap_in != 8'h00) && (dcnt < 2);
endmodule // asu_partner

// file: asu_status_unit_tb.sv
// self-checking bench for the adapter status unit
module asu_status_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asu_pkg::*;
  localparam int ord = 0, ope = 1, fix = 2, freq = 3, fdone = 4, cpe = 5, ncon = 6;
  localparam int pst = 7, qrd = 8, rdq = 9, qmax = 10, lqa = 11, otmp = 12, psu = 13;
  localparam int sel = 14, fin = 15, xst = 16, rpe = 17, tpe = 18, stb = 19, disc = 20;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [20:0] p = '0;
  logic ost = 1'h0, obad = 1'h0, sinv = 1'h0, sperr = 1'h0, unus = 1'h0;
  logic obusy = 1'h0, poll = 1'h0, xact = 1'h0, xrd = 1'h0, srd = 1'h0;
  logic fault = 1'h0, rep_en = 1'h0;
  logic [6:0] err2 = '0;
  logic [2:0] addr = '0;
  logic [7:0] gap = '0;
  asu_rsel_t ssel = ASU_RD_GEN;
  asu_mods_t ia = '0, ib = '0, mia, mib;
  asu_byte_t sdata, udata;
  logic [2:0] src;
  logic svalid, uvalid, int_a, int_b, dem, mfault, reply;
  int fails = 0, compares = 0, cyc = 0;
  asu_status_unit #(.NORESP_CYCLES(20), .IREQ_CYCLES(16)) u_dut (
    .MCLK_IN(clk), .RST_IN(rst), .OPER_BUSY_IN(obusy), .POLLING_IN(poll),
    .ORDER_IN(p[ord]), .ORDER_STATUS_IN(ost), .DISC_IN(p[disc]), .ORDER_BAD_IN(obad),
    .ORDER_PERR_IN(p[ope]), .FIXLEN_ERR_IN(p[fix]), .FETCH_REQ_IN(p[freq]),
    .FETCH_DONE_IN(p[fdone]), .CONST_PERR_IN(p[cpe]), .NO_CONSOLE_IN(p[ncon]),
    .POLL_STORED_IN(p[pst]), .QADDR_READ_IN(p[qrd]), .READ_QUEUE_IN(p[rdq]),
    .QADDR_MAX_IN(p[qmax]), .LOAD_QADDR_IN(p[lqa]), .OVERTEMP_IN(p[otmp]),
    .PSU_FAIL_IN(p[psu]), .ERR2_IN(err2), .INT_A_OUT(int_a), .INT_B_OUT(int_b),
    .STAT_RD_IN(srd), .STAT_SEL_IN(ssel), .STAT_DATA_OUT(sdata), .STAT_VALID_OUT(svalid),
    .MOD_INT_A_IN(mia), .MOD_INT_B_IN(mib), .SEL_IN(p[sel]), .SEL_ADDR_IN(addr),
    .SEL_INVALID_IN(sinv), .SEL_PERR_IN(sperr), .END_IN(p[fin]), .END_UNUSUAL_IN(unus),
    .USTAT_OUT(udata), .USTAT_SRC_OUT(src), .USTAT_VALID_OUT(uvalid),
    .XFER_ACTIVE_IN(xact), .XFER_READ_IN(xrd), .XFER_START_IN(p[xst]), .DEMAND_IN(dem),
    .MOD_FAULT_IN(mfault), .RD_PERR_IN(p[rpe]), .TXA_PERR_IN(p[tpe]),
    .STROBE_IN(p[stb]), .REPLY_IN(reply)
  );
  asu_partner u_partner (
    .clk_in(clk), .strobe_in(p[stb]), .reply_en_in(rep_en), .fault_in(fault),
    .int_a_in(ia), .int_b_in(ib), .gap_in(gap), .int_a_out(mia), .int_b_out(mib),
    .demand_out(dem), .fault_out(mfault), .reply_out(reply)
  );
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    p[i] = 1'h1;
    @(negedge clk);
    p[i] = 1'h0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input asu_rsel_t s, input logic [7:0] e);
    @(negedge clk);
    srd = 1'h1;
    ssel = s;
    @(negedge clk);
    srd = 1'h0;
    chk("stat_valid", {7'h00, svalid}, 8'h01);
    chk("stat_data", sdata, e);
  endtask
  task automatic ust(input logic v, input logic [7:0] e);
    logic seen;
    seen = (uvalid === 1'h1);
    for (int k = 0; k < 6 && !seen; k++) begin
      @(negedge clk);
      seen = (uvalid === 1'h1);
    end
    chk("ustat_valid", {7'h00, seen}, {7'h00, v});
    if (seen) begin
      chk("ustat", udata, e);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk("int_lines", {6'h00, int_a, int_b}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rd(asu_rsel_t'(k), 8'h00);
    end
  endtask
  task automatic t_fetch();
    pulse(freq);
    pulse(fdone);
    @(negedge clk);
    chk("int_a", {7'h00, int_a}, 8'h01);
    rd(ASU_RD_GEN, 8'h30);
    chk("int_a", {7'h00, int_a}, 8'h00);
    rd(ASU_RD_GEN, 8'h10);
    pulse(freq);
    rd(ASU_RD_GEN, 8'h00);
  endtask
  task automatic t_entry();
    pulse(pst);
    @(negedge clk);
    chk("int_b", {7'h00, int_b}, 8'h01);
    rd(ASU_RD_GEN, 8'h28);
    wt(25);
    rd(ASU_RD_GEN, 8'h09);
    rd(ASU_RD_ERR1, 8'h08);
    pulse(qrd);
    rd(ASU_RD_GEN, 8'h00);
    pulse(pst);
    pulse(rdq);
    wt(25);
    rd(ASU_RD_ERR1, 8'h00);
    pulse(qrd);
    rd(ASU_RD_GEN, 8'h20);
  endtask
  task automatic t_err1();
    pulse(otmp);
    pulse(psu);
    pulse(ope);
    pulse(cpe);
    pulse(fix);
    pulse(ncon);
    pulse(qmax);
    rd(ASU_RD_GEN, 8'h01);
    rd(ASU_RD_ERR1, 8'hF7);
    rd(ASU_RD_ERR1, 8'h01);
    pulse(lqa);
    rd(ASU_RD_ERR1, 8'h00);
    pulse(ncon);
    pulse(freq);
    rd(ASU_RD_ERR1, 8'h00);
  endtask
  task automatic t_err2();
    err2 = 7'h7F;
    obad = 1'h1;
    pulse(ord);
    err2 = 7'h00;
    obad = 1'h0;
    rd(ASU_RD_GEN, 8'h02);
    rd(ASU_RD_ERR2, 8'hFF);
    rd(ASU_RD_ERR2, 8'h00);
  endtask
  task automatic t_order();
    obusy = 1'h1;
    poll = 1'h1;
    pulse(ord);
    rd(ASU_RD_GEN, 8'hC4);
    ost = 1'h1;
    pulse(ord);
    rd(ASU_RD_ERR1, 8'h00);
    ost = 1'h0;
    pulse(ord);
    rd(ASU_RD_ERR1, 8'h04);
    pulse(disc);
    obusy = 1'h0;
    poll = 1'h0;
    rd(ASU_RD_GEN, 8'h00);
  endtask
  task automatic t_chan();
    addr = 3'h2;
    pulse(sel);
    ust(1'h0, 8'h00);
    addr = 3'h3;
    pulse(sel);
    ust(1'h1, 8'h50);
    unus = 1'h1;
    pulse(fin);
    ust(1'h1, 8'h2E);
    unus = 1'h0;
    pulse(sel);
    ust(1'h0, 8'h00);
    pulse(sel);
    ust(1'h1, 8'h10);
    pulse(fin);
    ust(1'h1, 8'h0C);
    sinv = 1'h1;
    pulse(sel);
    ust(1'h1, 8'h02);
    sinv = 1'h0;
    sperr = 1'h1;
    pulse(sel);
    ust(1'h1, 8'h02);
    sperr = 1'h0;
    pulse(fin);
    ust(1'h0, 8'h00);
    rd(ASU_RD_SENSE, 8'hA0);
  endtask
  task automatic t_att();
    addr = 3'h0;
    pulse(sel);
    ia = 5'h02;
    ib = 5'h08;
    ust(1'h0, 8'h00);
    ia = 5'h00;
    ib = 5'h00;
    pulse(fin);
    ust(1'h1, 8'hCC);
    chk("ustat_src", {5'h00, src}, 8'h01);
    @(negedge clk);
    ust(1'h1, 8'h81);
    chk("ustat_src", {5'h00, src}, 8'h03);
  endtask
  task automatic t_sense();
    xact = 1'h1;
    xrd = 1'h1;
    pulse(xst);
    pulse(rpe);
    fault = 1'h1;
    wt(4);
    fault = 1'h0;
    pulse(stb);
    wt(200);
    xact = 1'h0;
    rd(ASU_RD_SENSE, 8'h4D);
    xrd = 1'h0;
    gap = 8'h08;
    rep_en = 1'h1;
    xact = 1'h1;
    pulse(xst);
    pulse(stb);
    pulse(tpe);
    wt(200);
    xact = 1'h0;
    gap = 8'h00;
    rd(ASU_RD_SENSE, 8'h08);
  endtask
  ////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_fetch();
    t_entry();
    t_err1();
    t_err2();
    t_order();
    t_chan();
    t_att();
    t_sense();
    end_of_test();
  end
endmodule // asu_status_unit_tb
